// ### rtl/lia_buf_if.sv
// Connection between the register front end and the frame data buffer.
`timescale 1ns/1ns
interface lia_buf_if;
  logic wr_en;
  logic [2:0] wr_idx;
  logic [7:0] wr_data;
  logic [2:0] sw_idx;
  logic [7:0] sw_rdata;
  logic [2:0] eng_idx;
  logic [7:0] eng_rdata;
  modport ctrl (output wr_en, wr_idx, wr_data, sw_idx, eng_idx, input sw_rdata, eng_rdata);
  modport mem (input wr_en, wr_idx, wr_data, sw_idx, eng_idx, output sw_rdata, eng_rdata);
endinterface : lia_buf_if

// ### rtl/lia_frame_buf.sv
// Eight byte frame data buffer with registered read ports.
`timescale 1ns/1ns
module lia_frame_buf (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Buffer access
  lia_buf_if.mem bus
);
  import lia_pkg::*;
  logic [7:0] mem_reg [8];

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < 8; i++) begin
        mem_reg[i] <= LIA_REG_RST;
      end
    end else if (bus.wr_en) begin
      mem_reg[bus.wr_idx] <= bus.wr_data;
    end
  end

  // Write-through keeps the read register equal to the stored byte at every edge.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bus.sw_rdata <= LIA_REG_RST;
      bus.eng_rdata <= LIA_REG_RST;
    end else begin
      bus.sw_rdata <= (bus.wr_en && bus.wr_idx == bus.sw_idx) ? bus.wr_data : mem_reg[bus.sw_idx];
      bus.eng_rdata <= (bus.wr_en && bus.wr_idx == bus.eng_idx) ? bus.wr_data
                                                                : mem_reg[bus.eng_idx];
    end
  end
endmodule : lia_frame_buf

// ### rtl/lia_lin_regs.sv
// Register front end: pointer, data port, configuration and indirect registers.
`timescale 1ns/1ns
module lia_lin_regs (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Special function register bus
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_page_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  // Configuration towards the protocol engine
  output logic cfg_enable_o,
  output logic cfg_master_o,
  output logic cfg_auto_rate_o,
  // Control towards the protocol engine
  output logic [7:0] ctrl_o,
  output logic stop_pulse_o,
  output logic interrupt_reset_pulse_o,
  output logic error_reset_pulse_o,
  output logic start_pulse_o,
  output logic wakeup_pulse_o,
  input wire logic eng_req_clr_i,
  // Frame settings towards the protocol engine
  output logic [7:0] frame_length_checksum_o,
  output logic [7:0] baud_divider_low_o,
  output logic [7:0] baud_multiplier_prescale_o,
  output logic [7:0] frame_identifier_o,
  // Protocol engine events and data
  input wire logic eng_active_i,
  input wire logic [7:0] eng_status_set_i,
  input wire logic [lia_pkg::LIA_ERR_W-1:0] eng_err_set_i,
  input wire logic eng_buf_wr_i,
  input wire logic [2:0] eng_buf_idx_i,
  input wire logic [7:0] eng_buf_wdata_i,
  output logic [7:0] eng_buf_rdata_o,
  input wire logic eng_id_wr_i,
  input wire logic [7:0] eng_id_i
);
  import lia_pkg::*;

  logic [7:0] ptr_reg, ptr_next;
  logic [7:0] cfg_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] size_reg, div_reg, mul_reg, id_reg;
  logic [7:0] stat_flags;
  logic [LIA_ERR_W-1:0] err_flags;
  logic [7:0] status, acc_mask, wbits, rd_value;
  logic ptr_sel, dat_sel, cfg_sel, wr_dat, rd_dat, idx_ok, slave, buf_gate, is_data;
  logic err_pending;
  lia_buf_if buf_bus ();

  ////////////////////////////////////////////////////////////////////////////
  // Address decode.
  always_comb begin
    ptr_sel = 1'b0;
    dat_sel = 1'b0;
    cfg_sel = 1'b0;
    if (sfr_page_i == LIA_PAGE_PTR && sfr_addr_i == LIA_ADDR_PTR) begin
      ptr_sel = 1'b1;
    end else if (sfr_page_i == LIA_PAGE_PTR && sfr_addr_i == LIA_ADDR_DAT) begin
      dat_sel = 1'b1;
    end else if (sfr_page_i == LIA_PAGE_CFG && sfr_addr_i == LIA_ADDR_CFG) begin
      cfg_sel = 1'b1;
    end
  end

  assign slave = ~cfg_reg[LIA_CFG_MASTER];
  assign idx_ok = ptr_reg <= LIA_IDX_ID;
  assign is_data = ptr_reg <= LIA_IDX_DATA_LAST;
  // The engine owns buffer and identifier while a slave frame runs.
  assign buf_gate = ~slave | (stat_flags[LIA_S_DATA_REQUEST_PENDING] & ~eng_active_i);
  assign wr_dat = sfr_wr_i & dat_sel & idx_ok;
  assign rd_dat = sfr_rd_i & dat_sel;
  assign err_pending = |err_flags;

  // Bits that the current role may reach in the pointed register.
  always_comb begin
    acc_mask = 8'hFF;
    if (is_data || ptr_reg == LIA_IDX_ID) begin
      acc_mask = buf_gate ? 8'hFF : 8'h00;
    end else if (ptr_reg == LIA_IDX_CTRL) begin
      acc_mask = slave ? ~LIA_CTRL_MST : ~LIA_CTRL_SLV;
    end else if (ptr_reg == LIA_IDX_STAT) begin
      acc_mask = slave ? 8'hFF : ~LIA_STAT_SLV;
    end else if (ptr_reg == LIA_IDX_ERR) begin
      acc_mask = slave ? 8'hFF : ~LIA_ERR_SLV;
    end
  end

  assign wbits = sfr_wdata_i & acc_mask;

  ////////////////////////////////////////////////////////////////////////////
  // Direct registers.
  always_comb begin
    ptr_next = ptr_reg;
    if (sfr_wr_i && ptr_sel) begin
      ptr_next = sfr_wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ptr_reg <= LIA_PTR_RST;
    end else begin
      ptr_reg <= ptr_next;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_reg <= LIA_CFG_RST;
    end else if (sfr_wr_i && cfg_sel) begin
      cfg_reg <= sfr_wdata_i & LIA_CFG_MASK;
    end
  end

  assign cfg_enable_o = cfg_reg[LIA_CFG_EN];
  assign cfg_master_o = cfg_reg[LIA_CFG_MASTER];
  assign cfg_auto_rate_o = cfg_reg[LIA_CFG_AUTO] & slave;

  ////////////////////////////////////////////////////////////////////////////
  // Control register; write-only bits become pulses and read as zero.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_reg <= LIA_REG_RST;
    end else if (wr_dat && ptr_reg == LIA_IDX_CTRL) begin
      ctrl_reg <= (ctrl_reg & ~(acc_mask & LIA_CTRL_STORED)) | (wbits & LIA_CTRL_STORED);
      if (err_pending) begin
        ctrl_reg[LIA_C_START] <= 1'b0;
        ctrl_reg[LIA_C_WUP] <= 1'b0;
      end
    end else if (eng_req_clr_i) begin
      ctrl_reg[LIA_C_START] <= 1'b0;
      ctrl_reg[LIA_C_WUP] <= 1'b0;
      ctrl_reg[LIA_C_DATA_ACKNOWLEDGE] <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stop_pulse_o <= 1'b0;
      interrupt_reset_pulse_o <= 1'b0;
      error_reset_pulse_o <= 1'b0;
      start_pulse_o <= 1'b0;
      wakeup_pulse_o <= 1'b0;
    end else begin
      stop_pulse_o <= wr_dat && ptr_reg == LIA_IDX_CTRL && wbits[LIA_C_STOP];
      interrupt_reset_pulse_o <= wr_dat && ptr_reg == LIA_IDX_CTRL && wbits[LIA_C_INTRST];
      error_reset_pulse_o <= wr_dat && ptr_reg == LIA_IDX_CTRL && wbits[LIA_C_ERRRST];
      // A frame or wake-up starts only with the error flag clear.
      start_pulse_o <= wr_dat && ptr_reg == LIA_IDX_CTRL && wbits[LIA_C_START]
                       && !err_pending;
      wakeup_pulse_o <= wr_dat && ptr_reg == LIA_IDX_CTRL && wbits[LIA_C_WUP]
                        && !err_pending;
    end
  end

  assign ctrl_o = ctrl_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Status and error flags set by the engine.
  logic [7:0] stat_clr;
  logic [LIA_ERR_W-1:0] err_clr;
  logic ctrl_wr;

  assign ctrl_wr = wr_dat && ptr_reg == LIA_IDX_CTRL;
  always_comb begin
    stat_clr = 8'h00;
    if (ctrl_wr && wbits[LIA_C_INTRST]) begin
      stat_clr = stat_clr | LIA_STAT_INTCLR;
    end
    if (ctrl_wr && (wbits[LIA_C_DATA_ACKNOWLEDGE] || wbits[LIA_C_STOP])) begin
      stat_clr[LIA_S_DATA_REQUEST_PENDING] = 1'b1;
    end
  end
  assign err_clr = {LIA_ERR_W{ctrl_wr & wbits[LIA_C_ERRRST]}};

  lia_sticky #(.W(8)) u_stat (
    .clk_i (clk_i),
    .rstn_i (rstn_i),
    .set_i (eng_status_set_i & LIA_STAT_STICKY),
    .clr_i (stat_clr),
    .flag_o (stat_flags)
  );

  lia_sticky #(.W(LIA_ERR_W)) u_err (
    .clk_i (clk_i),
    .rstn_i (rstn_i),
    .set_i (eng_err_set_i),
    .clr_i (err_clr),
    .flag_o (err_flags)
  );

  always_comb begin
    status = stat_flags;
    status[LIA_S_ACTIVE] = eng_active_i;
    status[LIA_S_ERROR] = err_pending;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame settings; the engine loads the identifier it receives.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      size_reg <= LIA_REG_RST;
      div_reg <= LIA_REG_RST;
      mul_reg <= LIA_REG_RST;
    end else if (wr_dat) begin
      if (ptr_reg == LIA_IDX_SIZE) begin
        size_reg <= sfr_wdata_i & LIA_SIZE_MASK;
      end else if (ptr_reg == LIA_IDX_DIV) begin
        div_reg <= sfr_wdata_i;
      end else if (ptr_reg == LIA_IDX_MUL) begin
        mul_reg <= sfr_wdata_i;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      id_reg <= LIA_REG_RST;
    end else if (wr_dat && ptr_reg == LIA_IDX_ID && buf_gate) begin
      id_reg <= sfr_wdata_i & LIA_ID_MASK;
    end else if (eng_id_wr_i) begin
      id_reg <= eng_id_i & LIA_ID_MASK;
    end
  end

  assign frame_length_checksum_o = size_reg;
  assign baud_divider_low_o = div_reg;
  assign baud_multiplier_prescale_o = mul_reg;
  assign frame_identifier_o = id_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Data buffer; software has priority over the engine on the write port.
  assign buf_bus.wr_en = (wr_dat && is_data && buf_gate) || eng_buf_wr_i;
  assign buf_bus.wr_idx = (wr_dat && is_data && buf_gate) ? ptr_reg[2:0] : eng_buf_idx_i;
  assign buf_bus.wr_data = (wr_dat && is_data && buf_gate) ? sfr_wdata_i : eng_buf_wdata_i;
  // Addressed from the next pointer so a read right after a pointer write is current.
  assign buf_bus.sw_idx = ptr_next[2:0];
  assign buf_bus.eng_idx = eng_buf_idx_i;
  assign eng_buf_rdata_o = buf_bus.eng_rdata;

  lia_frame_buf u_buf (
    .clk_i (clk_i),
    .rstn_i (rstn_i),
    .bus (buf_bus.mem)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read data, registered at the access edge.
  always_comb begin
    rd_value = 8'h00;
    if (ptr_sel) begin
      rd_value = ptr_reg;
    end else if (cfg_sel) begin
      rd_value = cfg_reg;
    end else if (dat_sel && idx_ok) begin
      if (is_data) begin
        rd_value = buf_bus.sw_rdata & acc_mask;
      end else if (ptr_reg == LIA_IDX_CTRL) begin
        rd_value = ctrl_reg & LIA_CTRL_STORED & acc_mask;
      end else if (ptr_reg == LIA_IDX_STAT) begin
        rd_value = status & acc_mask;
      end else if (ptr_reg == LIA_IDX_ERR) begin
        rd_value = {{(8 - LIA_ERR_W){1'b0}}, err_flags} & acc_mask;
      end else if (ptr_reg == LIA_IDX_SIZE) begin
        rd_value = size_reg;
      end else if (ptr_reg == LIA_IDX_DIV) begin
        rd_value = div_reg;
      end else if (ptr_reg == LIA_IDX_MUL) begin
        rd_value = mul_reg;
      end else begin
        rd_value = id_reg & acc_mask;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (sfr_rd_i) begin
      sfr_rdata_o <= rd_value;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  a_ptr_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
    sfr_wr_i && ptr_sel |=> ptr_reg == $past(sfr_wdata_i))
    else $error("pointer did not take written value");
  a_cfg_low_zero: assert property (@(posedge clk_i) disable iff (!rstn_i)
    cfg_reg[4:0] == 5'h00)
    else $error("configuration low bits not zero");
  a_auto_slave: assert property (@(posedge clk_i) disable iff (!rstn_i)
    cfg_master_o |-> !cfg_auto_rate_o)
    else $error("auto rate active in master role");
  a_oob_read: assert property (@(posedge clk_i) disable iff (!rstn_i)
    rd_dat && ptr_reg > LIA_IDX_ID |=> sfr_rdata_o == 8'h00)
    else $error("out of range index read nonzero");
  a_size_rdback: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wr_dat && ptr_reg == LIA_IDX_SIZE ##1 !sfr_wr_i ##1 rd_dat && $stable(ptr_reg)
    |=> sfr_rdata_o == ($past(sfr_wdata_i, 3) & LIA_SIZE_MASK))
    else $error("size register read back wrong");
  a_start_blocked: assert property (@(posedge clk_i) disable iff (!rstn_i)
    err_pending |=> !start_pulse_o && !wakeup_pulse_o)
    else $error("start issued with error pending");
  a_err_clear: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ctrl_wr && wbits[LIA_C_ERRRST] && eng_err_set_i == '0 |=> !err_pending)
    else $error("error reset did not clear errors");
  a_slave_guard: assert property (@(posedge clk_i) disable iff (!rstn_i)
    slave && !buf_gate && wr_dat && is_data |-> !buf_bus.wr_en || eng_buf_wr_i)
    else $error("slave buffer write while engine owns it");
  // A start request left pending by the master may stand; a slave control write clears it only while an error is pending.
  a_master_only: assert property (@(posedge clk_i) disable iff (!rstn_i)
    slave && ctrl_wr |=> $stable(ctrl_reg[LIA_C_START]))
    else $error("master-only bit written in slave role");
endmodule : lia_lin_regs

// ### rtl/lia_pkg.sv
// Constants for the serial bus controller register front end.
// Contract
// - Eight-bit pointer register, read/write, resets zero.
// - Data port read returns pointed register.
// - Data port write stores into pointed register.
// - Pointer at 0xD3, data 0xD2, page 0x00.
// - Configuration at 0xC9 page 0x0F, resets 0x60.
// - Configuration bit 7 enables the interface.
// - Configuration bit 6: 1 master, 0 slave.
// - Bit 5 auto rate, effective only in slave.
// - Configuration bits 4:0 read zero, ignore writes.
// - Fifteen indirect registers at indices 0x00-0x0E.
// - Master-only and slave-only bits gated by mode.
// - Eight data byte registers, read/write, reset zero.
// - Control register at 0x08, fields, resets zero.
// - Slave buffer and identifier need request, idle bus.
// - Error reset clears errors; start needs no error.
package lia_pkg;
  localparam logic [7:0] LIA_ADDR_PTR = 8'hD3;
  localparam logic [7:0] LIA_ADDR_DAT = 8'hD2;
  localparam logic [7:0] LIA_PAGE_PTR = 8'h00;
  localparam logic [7:0] LIA_ADDR_CFG = 8'hC9;
  localparam logic [7:0] LIA_PAGE_CFG = 8'h0F;
  localparam logic [7:0] LIA_PTR_RST = 8'h00;
  localparam logic [7:0] LIA_CFG_RST = 8'h60;
  localparam logic [7:0] LIA_CFG_MASK = 8'hE0;
  localparam int LIA_CFG_EN = 7;
  localparam int LIA_CFG_MASTER = 6;
  localparam int LIA_CFG_AUTO = 5;
  localparam logic [7:0] LIA_IDX_DATA_LAST = 8'h07;
  localparam logic [7:0] LIA_IDX_CTRL = 8'h08;
  localparam logic [7:0] LIA_IDX_STAT = 8'h09;
  localparam logic [7:0] LIA_IDX_ERR = 8'h0A;
  localparam logic [7:0] LIA_IDX_SIZE = 8'h0B;
  localparam logic [7:0] LIA_IDX_DIV = 8'h0C;
  localparam logic [7:0] LIA_IDX_MUL = 8'h0D;
  localparam logic [7:0] LIA_IDX_ID = 8'h0E;
  localparam logic [7:0] LIA_REG_RST = 8'h00;
  // Control bit positions.
  localparam int LIA_C_STOP = 7;
  localparam int LIA_C_SLEEP = 6;
  localparam int LIA_C_DIRECTION_SELECT = 5;
  localparam int LIA_C_DATA_ACKNOWLEDGE = 4;
  localparam int LIA_C_INTRST = 3;
  localparam int LIA_C_ERRRST = 2;
  localparam int LIA_C_WUP = 1;
  localparam int LIA_C_START = 0;
  localparam logic [7:0] LIA_CTRL_STORED = 8'h73;
  // Status bit positions.
  localparam int LIA_S_ACTIVE = 7;
  localparam int LIA_S_ERROR = 2;
  localparam int LIA_S_DATA_REQUEST_PENDING = 4;
  localparam logic [7:0] LIA_STAT_INTCLR = 8'h6B;
  localparam logic [7:0] LIA_STAT_STICKY = 8'h7B;
  // Per register mode masks: bits reachable only in one role.
  localparam logic [7:0] LIA_CTRL_SLV = 8'hD0;
  localparam logic [7:0] LIA_CTRL_MST = 8'h01;
  localparam logic [7:0] LIA_STAT_SLV = 8'h30;
  localparam logic [7:0] LIA_ERR_SLV = 8'h18;
  localparam logic [7:0] LIA_SIZE_MASK = 8'h8F;
  localparam logic [7:0] LIA_ID_MASK = 8'h3F;
  localparam int LIA_ERR_W = 5;
endpackage : lia_pkg

// ### rtl/lia_sticky.sv
// Sticky flag bank where a set in the clear cycle wins.
`timescale 1ns/1ns
module lia_sticky #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Set and clear vectors
  input wire logic [W-1:0] set_i,
  input wire logic [W-1:0] clr_i,
  output logic [W-1:0] flag_o
);
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flag_o <= '0;
    end else begin
      flag_o <= (flag_o & ~clr_i) | set_i;
    end
  end
endmodule : lia_sticky

// ### tb/tb.sv
// Self-checking testbench for the serial bus controller register front end.
`timescale 1ns/1ns
module tb;
  import lia_pkg::*;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] sfr_addr_i = 8'h00;
  logic [7:0] sfr_page_i = 8'h00;
  logic sfr_wr_i = 1'b0;
  logic sfr_rd_i = 1'b0;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic [7:0] sfr_rdata_o;
  logic cfg_enable_o, cfg_master_o, cfg_auto_rate_o;
  logic [7:0] ctrl_o;
  logic stop_pulse_o, interrupt_reset_pulse_o, error_reset_pulse_o, start_pulse_o, wakeup_pulse_o;
  logic eng_req_clr_i = 1'b0;
  logic [7:0] frame_length_checksum_o, baud_divider_low_o;
  logic [7:0] baud_multiplier_prescale_o, frame_identifier_o;
  logic eng_active_i = 1'b0;
  logic [7:0] eng_status_set_i = 8'h00;
  logic [LIA_ERR_W-1:0] eng_err_set_i = '0;
  logic eng_buf_wr_i = 1'b0;
  logic [2:0] eng_buf_idx_i = 3'h0;
  logic [7:0] eng_buf_wdata_i = 8'h00;
  logic [7:0] eng_buf_rdata_o;
  logic eng_id_wr_i = 1'b0;
  logic [7:0] eng_id_i = 8'h00;
  int n_errors = 0;
  int n_tests = 0;
  int seed = 32'h7F2A;
  logic [7:0] rd, w, p;
  logic [7:0] dbuf [8];
  logic [7:0] outs [4];
  logic [7:0] masks [4];

  lia_lin_regs DUT (.clk_i(clk_i), .rstn_i(rstn_i), .sfr_addr_i(sfr_addr_i),
    .sfr_page_i(sfr_page_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
    .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .cfg_enable_o(cfg_enable_o),
    .cfg_master_o(cfg_master_o), .cfg_auto_rate_o(cfg_auto_rate_o), .ctrl_o(ctrl_o),
    .stop_pulse_o(stop_pulse_o), .interrupt_reset_pulse_o(interrupt_reset_pulse_o),
    .error_reset_pulse_o(error_reset_pulse_o), .start_pulse_o(start_pulse_o),
    .wakeup_pulse_o(wakeup_pulse_o), .eng_req_clr_i(eng_req_clr_i),
    .frame_length_checksum_o(frame_length_checksum_o), .baud_divider_low_o(baud_divider_low_o),
    .baud_multiplier_prescale_o(baud_multiplier_prescale_o),
    .frame_identifier_o(frame_identifier_o), .eng_active_i(eng_active_i),
    .eng_status_set_i(eng_status_set_i), .eng_err_set_i(eng_err_set_i),
    .eng_buf_wr_i(eng_buf_wr_i), .eng_buf_idx_i(eng_buf_idx_i),
    .eng_buf_wdata_i(eng_buf_wdata_i), .eng_buf_rdata_o(eng_buf_rdata_o),
    .eng_id_wr_i(eng_id_wr_i), .eng_id_i(eng_id_i));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #2 clk_i = ~clk_i;
  end

  // Reachable configuration bits only; the low five always read back clear.
  function automatic logic [7:0] exp_cfg(input logic [7:0] v);
    return v & 8'hE0;
  endfunction : exp_cfg

  // Stored control bits minus those that belong to the other role.
  function automatic logic [7:0] exp_ctrl(input logic [7:0] v, input logic mst);
    return v & 8'h73 & (mst ? 8'h2F : 8'hFE);
  endfunction : exp_ctrl

  task automatic check(input string name, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      $display("unexpected %s: expected %h, seen %h", name, e, g);
      n_errors++;
    end
  endtask : check

  task automatic end_of_test();
    $display("errors %0d, comparisons %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////////////////////
  // Strobes rise after a falling edge and drop one full cycle later.
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] pg, input logic [7:0] d);
    @(negedge clk_i);
    sfr_addr_i = a;
    sfr_page_i = pg;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    @(negedge clk_i);
    sfr_wr_i = 1'b0;
  endtask : sfr_wr

  task automatic sfr_rd(input logic [7:0] a, input logic [7:0] pg, output logic [7:0] d);
    @(negedge clk_i);
    sfr_addr_i = a;
    sfr_page_i = pg;
    sfr_rd_i = 1'b1;
    @(negedge clk_i);
    sfr_rd_i = 1'b0;
    d = sfr_rdata_o;
  endtask : sfr_rd

  task automatic ireg_wr(input logic [7:0] idx, input logic [7:0] d);
    sfr_wr(LIA_ADDR_PTR, LIA_PAGE_PTR, idx);
    sfr_wr(LIA_ADDR_DAT, LIA_PAGE_PTR, d);
  endtask : ireg_wr

  task automatic ireg_rd(input logic [7:0] idx, output logic [7:0] d);
    sfr_wr(LIA_ADDR_PTR, LIA_PAGE_PTR, idx);
    sfr_rd(LIA_ADDR_DAT, LIA_PAGE_PTR, d);
  endtask : ireg_rd

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #80000;
    n_errors++;
    end_of_test();
  end

  initial begin
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    rstn_i = 1'b1;
    sfr_rd(LIA_ADDR_PTR, LIA_PAGE_PTR, rd);
    check("pointer reset", 8'h00, rd);
    sfr_rd(LIA_ADDR_CFG, LIA_PAGE_CFG, rd);
    check("config reset", 8'h60, rd);
    check("config outputs reset", 8'h02, {5'h0, cfg_enable_o, cfg_master_o, cfg_auto_rate_o});
    for (int i = 0; i < 10; i++) begin
      w = (i == 0) ? 8'h3F : 8'($random(seed));
      sfr_wr(LIA_ADDR_CFG, LIA_PAGE_CFG, w);
      sfr_rd(LIA_ADDR_CFG, LIA_PAGE_CFG, rd);
      check("config readback", exp_cfg(w), rd);
      check("enable", {7'h0, w[7]}, {7'h0, cfg_enable_o});
      check("role", {7'h0, w[6]}, {7'h0, cfg_master_o});
      check("auto rate", {7'h0, w[5] & ~w[6]}, {7'h0, cfg_auto_rate_o});
    end
    // Unmapped places: wrong page for the pointer, wrong page for the configuration.
    sfr_wr(LIA_ADDR_PTR, LIA_PAGE_PTR, 8'h05);
    sfr_wr(LIA_ADDR_PTR, LIA_PAGE_CFG, 8'h55);
    sfr_rd(LIA_ADDR_PTR, LIA_PAGE_PTR, rd);
    check("pointer page", 8'h05, rd);
    sfr_rd(LIA_ADDR_CFG, LIA_PAGE_PTR, rd);
    check("config page", 8'h00, rd);
    sfr_wr(LIA_ADDR_CFG, LIA_PAGE_CFG, 8'hC0);
    for (int i = 0; i < 8; i++) begin
      dbuf[i] = 8'($random(seed));
      ireg_wr(i[7:0], dbuf[i]);
    end
    for (int i = 0; i < 8; i++) begin
      ireg_rd(i[7:0], rd);
      check("data byte", dbuf[i], rd);
    end
    @(negedge clk_i);
    eng_buf_wr_i = 1'b1;
    eng_buf_idx_i = 3'h3;
    eng_buf_wdata_i = 8'h5A;
    @(negedge clk_i);
    eng_buf_wr_i = 1'b0;
    @(negedge clk_i);
    check("engine buffer read", 8'h5A, eng_buf_rdata_o);
    ireg_rd(8'h03, rd);
    check("engine byte via port", 8'h5A, rd);
    masks = '{LIA_SIZE_MASK, 8'hFF, 8'hFF, LIA_ID_MASK};
    for (int k = 0; k < 4; k++) begin
      w = 8'($random(seed));
      ireg_wr(LIA_IDX_SIZE + k[7:0], w);
      outs = '{frame_length_checksum_o, baud_divider_low_o, baud_multiplier_prescale_o,
        frame_identifier_o};
      check("setting output", w & masks[k], outs[k]);
      sfr_rd(LIA_ADDR_DAT, LIA_PAGE_PTR, rd);
      check("setting readback", w & masks[k], rd);
    end
    @(negedge clk_i);
    eng_id_wr_i = 1'b1;
    eng_id_i = 8'hFF;
    @(negedge clk_i);
    eng_id_wr_i = 1'b0;
    check("engine identifier", 8'h3F, frame_identifier_o);
    for (int i = 0; i < 4; i++) begin
      p = 8'h0F + 8'({$random(seed)} % 241);
      sfr_wr(LIA_ADDR_PTR, LIA_PAGE_PTR, p);
      sfr_rd(LIA_ADDR_PTR, LIA_PAGE_PTR, rd);
      check("pointer readback", p, rd);
      sfr_wr(LIA_ADDR_DAT, LIA_PAGE_PTR, 8'hA5);
      sfr_rd(LIA_ADDR_DAT, LIA_PAGE_PTR, rd);
      check("beyond last index", 8'h00, rd);
    end
    check("identifier untouched", 8'h3F, frame_identifier_o);
    ireg_wr(LIA_IDX_CTRL, 8'hFF);
    check("start pulse master", 8'h01, {7'h0, start_pulse_o});
    check("control master", exp_ctrl(8'hFF, 1'b1), ctrl_o);
    sfr_rd(LIA_ADDR_DAT, LIA_PAGE_PTR, rd);
    check("control readback", exp_ctrl(8'hFF, 1'b1), rd);
    // Raise every error, then show that a start is held off until the reset.
    @(negedge clk_i);
    eng_err_set_i = 5'h1F;
    eng_req_clr_i = 1'b1;
    @(negedge clk_i);
    eng_err_set_i = '0;
    eng_req_clr_i = 1'b0;
    ireg_rd(LIA_IDX_ERR, rd);
    check("error flags master", 8'h07, rd);
    ireg_rd(LIA_IDX_STAT, rd);
    check("status error", 8'h04, rd);
    ireg_wr(LIA_IDX_CTRL, 8'h01);
    check("start blocked", 8'h00, {7'h0, start_pulse_o});
    check("control blocked", 8'h00, ctrl_o);
    sfr_wr(LIA_ADDR_DAT, LIA_PAGE_PTR, 8'h04);
    check("error reset pulse", 8'h01, {7'h0, error_reset_pulse_o});
    ireg_rd(LIA_IDX_ERR, rd);
    check("error cleared", 8'h00, rd);
    ireg_wr(LIA_IDX_CTRL, 8'h01);
    check("start after reset", 8'h01, {7'h0, start_pulse_o});
    // Slave role: buffer and identifier gated by a pending request and an idle bus.
    sfr_wr(LIA_ADDR_CFG, LIA_PAGE_CFG, 8'hA0);
    ireg_wr(8'h02, 8'hC3);
    ireg_rd(8'h02, rd);
    check("slave no request", 8'h00, rd);
    @(negedge clk_i);
    eng_status_set_i = 8'h10;
    @(negedge clk_i);
    eng_status_set_i = 8'h00;
    ireg_rd(LIA_IDX_STAT, rd);
    check("status request", 8'h10, rd);
    ireg_rd(8'h02, rd);
    check("slave old byte", dbuf[2], rd);
    ireg_wr(8'h02, 8'hC3);
    ireg_rd(8'h02, rd);
    check("slave write", 8'hC3, rd);
    eng_active_i = 1'b1;
    ireg_rd(LIA_IDX_ID, rd);
    check("slave bus active", 8'h00, rd);
    eng_active_i = 1'b0;
    ireg_wr(LIA_IDX_CTRL, 8'hFF);
    check("stop pulse", 8'h01, {7'h0, stop_pulse_o});
    check("wakeup pulse", 8'h01, {7'h0, wakeup_pulse_o});
    check("interrupt reset pulse", 8'h01, {7'h0, interrupt_reset_pulse_o});
    // The start request set in the master role is still pending and out of reach.
    check("control slave", exp_ctrl(8'hFF, 1'b0) | 8'h01, ctrl_o);
    end_of_test();
  end
endmodule : tb
